// ### wdhc_control.sv
// Purpose: Watchdog timer, power-down entry, wake-up and start-up delay.
// Assumes: core_clk is the 200 MHz system clock; the watchdog RC
//          oscillator arrives as a pin and is sampled on core_clk.
// Notes:   Every pin passes two flops before any logic reads it.
`timescale 1ns/100ps
`default_nettype none
`include "wdhc_map.svh"

module wdhc_control (
  // Clock and power-on reset.
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // Fixed options and watchdog prescaler select.
  input  wire wdhc_pkg::wdhc_cfg_s    cfg,
  input  wire logic [`WDHC_PSC_W-1:0] wdt_psc,
  // Instruction strobes and interrupt state from the core.
  input  wire wdhc_pkg::wdhc_cmd_s    cmd,
  input  wire wdhc_pkg::wdhc_irq_s    irq,
  // Asynchronous pins.
  input  wire logic                   wdt_osc_in,
  input  wire logic                   ext_init_pin_n,
  input  wire logic [`WDHC_PA_W-1:0]  pa_pins,
  // Status flags.
  output logic                        timeout_flag,
  output logic                        powerdown_flag,
  // Reset and run control towards the core.
  output logic                        chip_reset,
  output logic                        warm_reset,
  output logic                        core_run,
  output logic                        sys_osc_run,
  output logic                        resume_next,
  output logic                        int_ack,
  // Divided clock pin.
  output logic                        clock_out_pin
);

  wdhc_pkg::wdhc_state_s st_reg;
  wdhc_pkg::wdhc_state_s st_next;

  logic                   use_osc;
  logic                   osc_tick;
  logic                   instr_tick;
  logic                   wdt_tick;
  logic                   running;
  logic                   ext_low;
  logic                   single_clear;
  logic                   pair_clear;
  logic                   sw_clear;
  logic                   halt_go;
  logic                   wdt_clear;
  logic                   wdt_ovf;
  logic                   pa_fall;
  logic [`WDHC_INT_W-1:0] int_new;
  logic                   int_serve;

  // ********************************************************
  // Clock selection and clear decode.
  // ********************************************************

  // A disabled oscillator leaves the instruction clock as the source.
  always_comb begin
    use_osc    = cfg.wdt_osc_src && cfg.wdt_osc_enable;
    osc_tick   = st_reg.osc_sync && !st_reg.osc_prev;
    running    = st_reg.mode == wdhc_pkg::WDHC_RUN;
    instr_tick = running && st_reg.phase == `WDHC_ICLK_LAST;
    wdt_tick   = cfg.wdt_enable && (use_osc ? osc_tick : instr_tick);
    ext_low    = !st_reg.ext_sync;
  end

  // Clear instructions act only while running with the watchdog on.
  always_comb begin
    single_clear = cfg.wdt_enable && running && !cfg.clear_twice
                   && cmd.watchdog_clear_op;
    pair_clear   = cfg.wdt_enable && running && cfg.clear_twice
                   && (st_reg.first_seen || cmd.watchdog_clear_first_op)
                   && (st_reg.second_seen
                       || cmd.watchdog_clear_second_op);
    sw_clear     = single_clear || pair_clear;
    halt_go      = running && !st_reg.chip_reset && cmd.halt_op;
    wdt_clear    = cfg.wdt_enable
                   && (ext_low || sw_clear || halt_go);
  end

  // Wake sources seen while halted.
  always_comb begin
    pa_fall   = |(st_reg.pa_prev & ~st_reg.pa_sync & cfg.pa_wake_en);
    int_new   = irq.req & ~st_reg.int_snap;
    int_serve = |(int_new & irq.en) && irq.master_en
                && !irq.stack_full;
  end

  // ********************************************************
  // Divide chain.
  // ********************************************************

  // Base stage and prescaler share one counter.
  wdhc_divider u_divider (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (wdt_tick),
    .clear    (wdt_clear),
    .psc      (wdt_psc),
    .ovf      (wdt_ovf)
  );

  // ********************************************************
  // Next state.
  // ********************************************************

  always_comb begin
    st_next             = st_reg;
    st_next.warm_reset  = 1'b0;
    st_next.resume_next = 1'b0;
    st_next.int_ack     = 1'b0;

    // Two flops on every pin before any logic looks at it.
    st_next.osc_meta = wdt_osc_in;
    st_next.osc_sync = st_reg.osc_meta;
    st_next.osc_prev = st_reg.osc_sync;
    st_next.ext_meta = ext_init_pin_n;
    st_next.ext_sync = st_reg.ext_meta;
    st_next.pa_meta  = pa_pins;
    st_next.pa_sync  = st_reg.pa_meta;
    st_next.pa_prev  = st_reg.pa_sync;

    // System oscillator is off in halt, so the phase freezes there.
    if (st_reg.mode != wdhc_pkg::WDHC_HALT) begin
      st_next.phase = st_reg.phase + `WDHC_ICLK_W'(1);
    end
    st_next.clk_out = cfg.rc_mode && st_next.phase[`WDHC_ICLK_W-1];

    // Two-clear tracking; a finished pair or a chip reset starts over,
    // so that a half pair from before a reset cannot complete later.
    if (pair_clear || st_reg.chip_reset || !cfg.clear_twice
        || !cfg.wdt_enable) begin
      st_next.first_seen  = 1'b0;
      st_next.second_seen = 1'b0;
    end else if (running) begin
      st_next.first_seen  = st_reg.first_seen
                            || cmd.watchdog_clear_first_op;
      st_next.second_seen = st_reg.second_seen
                            || cmd.watchdog_clear_second_op;
    end

    // Flags: the timeout set is applied last so that it wins.
    if (sw_clear) begin
      st_next.powerdown_flag = 1'b0;
      st_next.timeout_flag   = 1'b0;
    end
    if (halt_go) begin
      st_next.powerdown_flag = 1'b1;
      st_next.timeout_flag   = 1'b0;
    end
    if (wdt_ovf && st_reg.mode != wdhc_pkg::WDHC_DUMMY) begin
      st_next.timeout_flag = 1'b1;
    end

    unique case (st_reg.mode)
      wdhc_pkg::WDHC_RUN: begin
        if (ext_low || wdt_ovf) begin
          st_next.chip_reset = 1'b1;
          st_next.mode       = wdhc_pkg::WDHC_DUMMY;
          st_next.wake       = wdhc_pkg::WDHC_WK_RESET;
          st_next.sst        = `WDHC_SST_ZERO;
        end else if (halt_go) begin
          st_next.mode     = wdhc_pkg::WDHC_HALT;
          st_next.int_snap = irq.req;
        end
      end
      wdhc_pkg::WDHC_HALT: begin
        st_next.sst = `WDHC_SST_ZERO;
        if (ext_low) begin
          st_next.chip_reset = 1'b1;
          st_next.mode       = wdhc_pkg::WDHC_DUMMY;
          st_next.wake       = wdhc_pkg::WDHC_WK_RESET;
        end else if (wdt_ovf) begin
          st_next.warm_reset = 1'b1;
          st_next.mode       = wdhc_pkg::WDHC_DUMMY;
          st_next.wake       = wdhc_pkg::WDHC_WK_WARM;
        end else if (|int_new) begin
          st_next.mode = wdhc_pkg::WDHC_DUMMY;
          st_next.wake = int_serve ? wdhc_pkg::WDHC_WK_INTACK
                                   : wdhc_pkg::WDHC_WK_NEXT;
        end else if (pa_fall) begin
          st_next.mode = wdhc_pkg::WDHC_DUMMY;
          st_next.wake = wdhc_pkg::WDHC_WK_NEXT;
        end
      end
      wdhc_pkg::WDHC_DUMMY: begin
        // A held reset pin keeps the delay from starting.
        if (ext_low) begin
          st_next.chip_reset = 1'b1;
          st_next.wake       = wdhc_pkg::WDHC_WK_RESET;
          st_next.sst        = `WDHC_SST_ZERO;
        end else if (st_reg.sst == `WDHC_SST_CYC - `WDHC_SST_ONE) begin
          st_next.mode        = wdhc_pkg::WDHC_RUN;
          st_next.chip_reset  = 1'b0;
          st_next.resume_next = st_reg.wake == wdhc_pkg::WDHC_WK_NEXT;
          st_next.int_ack     = st_reg.wake == wdhc_pkg::WDHC_WK_INTACK;
        end else begin
          st_next.sst = st_reg.sst + `WDHC_SST_ONE;
        end
      end
      default: begin
        // An illegal code restarts the device through the delay.
        st_next.mode       = wdhc_pkg::WDHC_DUMMY;
        st_next.wake       = wdhc_pkg::WDHC_WK_RESET;
        st_next.chip_reset = 1'b1;
        st_next.sst        = `WDHC_SST_ZERO;
      end
    endcase
  end

  // ********************************************************
  // State register.
  // ********************************************************

  // Power-up reset clears both flags and runs the start-up delay.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg            <= '0;
      st_reg.mode       <= wdhc_pkg::WDHC_DUMMY;
      st_reg.wake       <= wdhc_pkg::WDHC_WK_RESET;
      st_reg.chip_reset <= 1'b1;
      st_reg.ext_meta   <= 1'b1;
      st_reg.ext_sync   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign timeout_flag   = st_reg.timeout_flag;
  assign powerdown_flag = st_reg.powerdown_flag;
  assign chip_reset     = st_reg.chip_reset;
  assign warm_reset     = st_reg.warm_reset;
  assign core_run       = st_reg.mode == wdhc_pkg::WDHC_RUN;
  assign sys_osc_run    = st_reg.mode != wdhc_pkg::WDHC_HALT;
  assign resume_next    = st_reg.resume_next;
  assign int_ack        = st_reg.int_ack;
  assign clock_out_pin  = st_reg.clk_out;

  // ********************************************************
  // Checks.
  // ********************************************************

  AST_CLKOUT_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
    !cfg.rc_mode |=> !clock_out_pin)
    else $error("Clock out toggles outside RC mode.");

  AST_WDT_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
    !cfg.wdt_enable |=> !wdt_ovf)
    else $error("Disabled watchdog overflowed.");

  AST_HALT_ICLK: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_reg.mode == wdhc_pkg::WDHC_HALT && !use_osc) |-> !wdt_tick)
    else $error("Instruction clock counted during halt.");

  AST_RUN_OVF: assert property (@(posedge core_clk) disable iff (!rstn)
    (running && wdt_ovf) |=> chip_reset && timeout_flag && !core_run)
    else $error("Overflow while running gave no chip reset.");

  AST_HALT_OVF: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_reg.mode == wdhc_pkg::WDHC_HALT && wdt_ovf && !ext_low)
    |=> warm_reset && timeout_flag && !chip_reset ##1 !warm_reset)
    else $error("Overflow in halt gave no warm reset pulse.");

  AST_HALT_FLAGS: assert property (@(posedge core_clk) disable iff (!rstn)
    (halt_go && !wdt_ovf && !ext_low)
    |=> powerdown_flag && !timeout_flag && !sys_osc_run)
    else $error("Halt entry flags wrong.");

  AST_CLEAR_PD: assert property (@(posedge core_clk) disable iff (!rstn)
    (sw_clear && !halt_go) |=> !powerdown_flag)
    else $error("Clear instruction left powerdown flag set.");

  AST_STALE_INT: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_reg.mode == wdhc_pkg::WDHC_HALT && int_new == '0 && !pa_fall
     && !wdt_ovf && !ext_low) |=> st_reg.mode == wdhc_pkg::WDHC_HALT)
    else $error("Halt left without a wake event.");

  AST_PA_WAKE: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_reg.mode == wdhc_pkg::WDHC_HALT && pa_fall && int_new == '0
     && !wdt_ovf && !ext_low)
    |=> st_reg.mode == wdhc_pkg::WDHC_DUMMY
        && st_reg.wake == wdhc_pkg::WDHC_WK_NEXT)
    else $error("Port edge did not wake to next instruction.");

  AST_SST_LEN: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(core_run) |-> $past(st_reg.sst) == `WDHC_SST_CYC - `WDHC_SST_ONE)
    else $error("Run resumed before the full dummy delay.");

  AST_RESUME_KIND: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(core_run) |-> int_ack == ($past(st_reg.wake) == wdhc_pkg::WDHC_WK_INTACK)
                        && resume_next == ($past(st_reg.wake) == wdhc_pkg::WDHC_WK_NEXT))
    else $error("Wrong resume pulse after dummy delay.");

endmodule : wdhc_control
`default_nettype wire

// ### wdhc_map.svh
// Purpose: Named widths, counts and reset values for the watchdog block.
// Assumes: Included by the package and by every design file.
// Notes:   Definitions only.
`ifndef WDHC_MAP_SVH
`define WDHC_MAP_SVH

// Port A and interrupt source widths.
`define WDHC_PA_W       8
`define WDHC_INT_W      3

// Divide chain: 8-stage base, 3-bit prescaler select, 15-bit count.
`define WDHC_PSC_W      3
`define WDHC_CNT_W      15
`define WDHC_BASE_SHIFT 4'h8
`define WDHC_CNT_ZERO   15'h0000

// Instruction clock is the system clock divided by 4.
`define WDHC_ICLK_W     2
`define WDHC_ICLK_LAST  2'h3
`define WDHC_ICLK_ZERO  2'h0

// Start-up dummy delay of 1024 system clock periods.
`define WDHC_SST_W      11
`define WDHC_SST_CYC    11'h400
`define WDHC_SST_ZERO   11'h000
`define WDHC_SST_ONE    11'h001

`endif

// ### wdhc_pkg.sv
// Purpose: Types shared by the watchdog and power-down control files.
// Assumes: wdhc_map.svh supplies all widths.
// Notes:   No constants are kept here beyond type encodings.
`include "wdhc_map.svh"

package wdhc_pkg;

  // Operating mode; RUN to HALT to DUMMY steps one bit at a time.
  typedef enum logic [1:0] {
    WDHC_RUN   = 2'h0,
    WDHC_HALT  = 2'h1,
    WDHC_DUMMY = 2'h3
  } wdhc_mode_e;

  // What the core does once the dummy delay ends.
  typedef enum logic [1:0] {
    WDHC_WK_NEXT   = 2'h0,
    WDHC_WK_INTACK = 2'h1,
    WDHC_WK_RESET  = 2'h2,
    WDHC_WK_WARM   = 2'h3
  } wdhc_wake_e;

  // Fixed configuration options.
  typedef struct packed {
    logic                  wdt_enable;
    logic                  wdt_osc_src;
    logic                  wdt_osc_enable;
    logic                  clear_twice;
    logic                  rc_mode;
    logic [`WDHC_PA_W-1:0] pa_wake_en;
  } wdhc_cfg_s;

  // One-cycle instruction strobes from the core.
  typedef struct packed {
    logic watchdog_clear_op;
    logic watchdog_clear_first_op;
    logic watchdog_clear_second_op;
    logic halt_op;
  } wdhc_cmd_s;

  // Interrupt request flags and the enables that gate them.
  typedef struct packed {
    logic [`WDHC_INT_W-1:0] req;
    logic [`WDHC_INT_W-1:0] en;
    logic                   master_en;
    logic                   stack_full;
  } wdhc_irq_s;

  // State of the divide chain.
  typedef struct packed {
    logic [`WDHC_CNT_W-1:0] cnt;
    logic                   ovf;
  } wdhc_div_s;

  // State of the control block.
  typedef struct packed {
    wdhc_mode_e             mode;
    wdhc_wake_e             wake;
    logic [`WDHC_SST_W-1:0] sst;
    logic [`WDHC_ICLK_W-1:0] phase;
    logic                   clk_out;
    logic                   osc_meta;
    logic                   osc_sync;
    logic                   osc_prev;
    logic                   ext_meta;
    logic                   ext_sync;
    logic [`WDHC_PA_W-1:0]  pa_meta;
    logic [`WDHC_PA_W-1:0]  pa_sync;
    logic [`WDHC_PA_W-1:0]  pa_prev;
    logic [`WDHC_INT_W-1:0] int_snap;
    logic                   first_seen;
    logic                   second_seen;
    logic                   timeout_flag;
    logic                   powerdown_flag;
    logic                   chip_reset;
    logic                   warm_reset;
    logic                   resume_next;
    logic                   int_ack;
  } wdhc_state_s;

endpackage : wdhc_pkg

// ### wdhc_divider.sv
// Purpose: Watchdog divide chain with base stage and prescaler.
// Assumes: tick is a one-cycle pulse on core_clk.
// Notes:   Clear wins over a coinciding overflow.
`timescale 1ns/100ps
`default_nettype none
`include "wdhc_map.svh"

module wdhc_divider (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // Count control.
  input  wire logic                   tick,
  input  wire logic                   clear,
  input  wire logic [`WDHC_PSC_W-1:0] psc,
  // Overflow pulse.
  output logic                        ovf
);

  wdhc_pkg::wdhc_div_s div_reg;
  wdhc_pkg::wdhc_div_s div_next;

  // Last count before overflow: 256 ticks shifted up by the prescaler.
  function automatic logic [`WDHC_CNT_W-1:0] wdhc_last(
    input logic [`WDHC_PSC_W-1:0] sel);
    return ~({`WDHC_CNT_W{1'b1}} << ({1'b0, sel} + `WDHC_BASE_SHIFT));
  endfunction : wdhc_last

  // ********************************************************
  // Count and overflow.
  // ********************************************************

  // Overflow restarts the chain so that a held-off clear still times out.
  always_comb begin
    div_next     = div_reg;
    div_next.ovf = 1'b0;
    if (clear) begin
      div_next.cnt = `WDHC_CNT_ZERO;
    end else if (tick) begin
      if (div_reg.cnt == wdhc_last(psc)) begin
        div_next.cnt = `WDHC_CNT_ZERO;
        div_next.ovf = 1'b1;
      end else begin
        div_next.cnt = div_reg.cnt + `WDHC_CNT_W'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign ovf = div_reg.ovf;

  // Overflow only follows a tick taken at the last count.
  AST_DIV_OVF_CAUSE: assert property (@(posedge core_clk) disable iff (!rstn)
    ovf |-> $past(tick) && !$past(clear) && $past(div_reg.cnt) == $past(wdhc_last(psc)))
    else $error("Watchdog overflow without reaching the last count.");

endmodule : wdhc_divider
`default_nettype wire

// ### wdhc_pin_model.sv
// Purpose: Far side of the block: reset pin, port A pins, watchdog RC osc.
// Assumes: The reset pin and port A have pull-ups.
// Notes:   The oscillator runs free unless switched off by option.
`timescale 1ns/100ps
`default_nettype none
`include "wdhc_map.svh"

module wdhc_pin_model (
  // Controls from the bench.
  input  wire logic                  osc_on,
  input  wire logic                  ext_low,
  input  wire logic [`WDHC_PA_W-1:0] pa_low,
  // Pins towards the block.
  output logic                       wdt_osc_in,
  output logic                       ext_init_pin_n,
  output logic [`WDHC_PA_W-1:0]      pa_pins
);
  // ************
  // Pin drivers
  // ************
  // A released pin floats up to its pull-up level.
  assign ext_init_pin_n = ~ext_low;
  assign pa_pins        = ~pa_low;

  // The period is no multiple of core_clk, so phases drift as in silicon.
  initial begin
    wdt_osc_in = 1'h0;
    forever begin
      #10.3;
      wdt_osc_in = osc_on ? ~wdt_osc_in : 1'h0;
    end
  end
endmodule : wdhc_pin_model
`default_nettype wire

// ### test_watchdog_halt_wakeup_control.sv
// Purpose: Self-checking bench for the watchdog and halt controller.
// Assumes: Options change only across a reset.
// Notes:   Options word is {en, osc src, osc en, twice, rc, wake en}.
`timescale 1ns/100ps
`default_nettype none
`include "wdhc_map.svh"

module test_watchdog_halt_wakeup_control;
  localparam int WDT_CYC = 256 * 4;
  logic                  core_clk   = 1'h0;
  logic                  rstn       = 1'h0;
  wdhc_pkg::wdhc_cfg_s   cfg        = '0;
  wdhc_pkg::wdhc_cmd_s   cmd        = '0;
  wdhc_pkg::wdhc_irq_s   irq        = '0;
  logic                  ext_low    = 1'h0;
  logic [`WDHC_PA_W-1:0] pa_low     = '0;
  logic [`WDHC_PSC_W-1:0] psc       = '0;
  logic [`WDHC_PA_W-1:0] pa;
  logic                  osc;
  logic                  ext_n;
  logic                  to_f;
  logic                  pd_f;
  logic                  crst;
  logic                  wrst;
  logic                  run;
  logic                  sosc;
  logic                  rnext;
  logic                  iack;
  logic                  cko;
  logic [7:0]            v;
  int                    mismatches = 0;
  int                    n_compared = 0;
  int                    n;

  // 200 MHz system clock.
  always #2.5 core_clk = ~core_clk;

  wdhc_pin_model pins (.osc_on(cfg.wdt_osc_enable), .ext_low(ext_low),
    .pa_low(pa_low), .wdt_osc_in(osc), .ext_init_pin_n(ext_n), .pa_pins(pa));

  wdhc_control dut (.core_clk(core_clk), .rstn(rstn), .cfg(cfg),
    .wdt_psc(psc), .cmd(cmd), .irq(irq), .wdt_osc_in(osc),
    .ext_init_pin_n(ext_n), .pa_pins(pa), .timeout_flag(to_f),
    .powerdown_flag(pd_f), .chip_reset(crst), .warm_reset(wrst),
    .core_run(run), .sys_osc_run(sosc), .resume_next(rnext),
    .int_ack(iack), .clock_out_pin(cko));

  // *************
  // Access tasks
  // *************
  task automatic print_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  // The idle cycle after the strobe keeps back-to-back calls apart.
  task automatic pulse(input logic [3:0] c);
    cmd = c;
    cyc(1);
    cmd = '0;
    cyc(1);
  endtask : pulse

  // Cycles until run, chip reset or warm reset reads high; -1 if never.
  task automatic watch(input int sel, input int lim, output int k);
    logic s;
    k = 0;
    s = 1'h0;
    while (s !== 1'h1 && k < lim) begin
      cyc(1);
      k++;
      s = (sel == 0) ? run : (sel == 1) ? crst : wrst;
    end
    if (s !== 1'h1) k = -1;
  endtask : watch

  task automatic do_reset(input logic [12:0] c);
    rstn = 1'h0;
    cfg = c;
    cyc(4);
    check(!to_f && !pd_f && crst && !run, "reset values");
    rstn = 1'h1;
    watch(0, 1100, n);
    check(n >= 1024 && n <= 1030, "start-up delay");
  endtask : do_reset

  // *********
  // Scenarios
  // *********
  initial begin
    do_reset(13'h1501);
    for (int i = 0; i < 8; i++) begin
      v[i] = cko;
      cyc(1);
    end
    check(v[3:0] === v[7:4] && $countones(v[3:0]) == 2, "clock out");
    pulse(4'h1);
    check(pd_f && !to_f && !run && !sosc, "halt entry");
    pa_low = 8'h02;
    watch(0, 1500, n);
    check(n == -1 && !to_f, "woke in halt");
    pa_low = 8'h03;
    watch(0, 1100, n);
    check(n >= 1024 && n <= 1032 && rnext && !iack, "port wake");
    pa_low = 8'h00;
    pulse(4'h8);
    check(!pd_f, "clear op left powerdown flag");
    irq.req = 3'h1;
    irq.en = 3'h7;
    irq.master_en = 1'h1;
    for (int k = 0; k < 2; k++) begin
      irq.stack_full = k[0];
      pulse(4'h1);
      watch(0, 60, n);
      check(n == -1, "pending request woke");
      irq.req = 3'h3;
      watch(0, 1100, n);
      check(iack === !k[0] && rnext === k[0], "interrupt wake");
      irq.req = 3'h1;
      pulse(4'h8);
    end
    pulse(4'h1);
    ext_low = 1'h1;
    cyc(10);
    check(crst && !to_f && pd_f, "reset pin in halt");
    ext_low = 1'h0;
    watch(0, 1100, n);
    pulse(4'h8);
    watch(1, 1100, n);
    check(n >= WDT_CYC - 8 && n <= WDT_CYC + 8 && to_f, "timeout");
    watch(0, 1100, n);
    repeat (4) begin
      pulse(4'h8);
      watch(1, 600, n);
      check(n == -1, "cleared watchdog fired");
    end
    // One prescaler step doubles the timeout.
    psc = 3'h1;
    pulse(4'h8);
    watch(1, 1500, n);
    check(n == -1, "prescaler timed out early");
    watch(1, 700, n);
    check(n >= 540 && n <= 556 && to_f, "prescaler timeout");
    psc = 3'h0;
    // Watchdog switched off by option never fires.
    do_reset(13'h0501);
    watch(1, 2000, n);
    check(n == -1, "disabled watchdog fired");
    // Two-op mode: first op alone, even with the single op, is no clear.
    do_reset(13'h1701);
    cyc(600);
    pulse(4'hC);
    watch(1, 600, n);
    check(n != -1, "partial clear took");
    watch(0, 1100, n);
    repeat (4) begin
      pulse(4'h2);
      cyc(100);
      pulse(4'h4);
      watch(1, 500, n);
      check(n == -1, "paired clear failed");
    end
    // Oscillator source: halt restarts the count, overflow is warm.
    do_reset(13'h1D01);
    pulse(4'h1);
    watch(2, 1200, n);
    check(n >= 1000 && !crst && to_f && pd_f, "warm reset");
    watch(0, 1100, n);
    check(n != -1 && !rnext, "warm resume");
    // Oscillator chosen but switched off: instruction clock, frozen in halt.
    do_reset(13'h1901);
    pulse(4'h1);
    watch(2, 1500, n);
    check(n == -1 && !to_f, "halted watchdog ran");
    print_verdict;
  end

  // Hang guard, well past the expected run length.
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    $display("unexpected at %0t ns: run hung", $time);
    print_verdict;
  end
endmodule : test_watchdog_halt_wakeup_control
`default_nettype wire
